// *** hdl/hbg_regs.vh ***
// Constants for the 8-bit host bus glue port: window map, strap positions, reset values
// How it works
// R01 - Host cycles timed by separate bus clock
// R02 - Host wires address and data pins directly
// R03 - Host mirrors CPU byte on both lanes
// R04 - Host decodes 128K window into chip select
// R05 - Host drives high enable from inverted bit zero
// R06 - Host pulls write strobe low to write
// R07 - Host pulls read strobe low to read
// R08 - Wait held until arbitration completes
// R09 - Host inverts wait if it needs high
// R10 - Bus status and direction pins tied high
// R11 - Straps latched at reset release
// R12 - Strap three picks little or big endian
// R13 - Strap four sets panel power polarity
// R14 - All-ones config and bus straps select 16-bit generic mode
// R15 - Buffer at zero, registers in top 32
// R16 - Without A16 memory is partly unreachable
`ifndef HBG_REGS_VH
`define HBG_REGS_VH

`define HBG_ADDR_W        17
`define HBG_BUF_BASE      17'h00000
`define HBG_BUF_LAST      17'h13FFF
`define HBG_REG_BASE      17'h1FFE0
`define HBG_REG_LAST      17'h1FFFF

`define HBG_STRAP_W       6
`define HBG_STRAP_CFG0    0
`define HBG_STRAP_CFG1    1
`define HBG_STRAP_CFG2    2
`define HBG_STRAP_ORDER   3
`define HBG_STRAP_POWER   4
`define HBG_STRAP_BUS     5
`define HBG_MODE_GENERIC  4'hF

`define HBG_STRAP_RESET   6'h00
`define HBG_WORD_RESET    16'h0000
`define HBG_ADDR_RESET    17'h00000

`endif

// *** hdl/hbg_host_port.v ***
// Host bus port of the display controller in 16-bit generic mode, fed by 8-bit glue
`timescale 1ns/1ps
`include "hbg_regs.vh"

module hbg_host_port
(
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire        host_transfer_clock,
	input  wire [16:1] host_address_pins,
	input  wire        address_bit_zero,
	input  wire [15:0] host_data_pins_in,
	output wire [15:0] host_data_pins_out,
	output wire        host_data_pins_oe,
	input  wire        host_select_n,
	input  wire        high_byte_enable_n,
	input  wire        write_strobe_n,
	input  wire        host_read_n,
	input  wire        host_dir_pin,
	output wire        host_wait_n,
	input  wire        bus_status_strap,
	input  wire        config_strap_0,
	input  wire        config_strap_1,
	input  wire        config_strap_2,
	input  wire        byte_order_strap,
	input  wire        panel_power_polarity_strap,
	input  wire        panel_power_on,
	output wire        panel_power_control,
	output wire        generic_mode,
	output wire        big_endian,
	output wire        mem_req,
	output wire        mem_we,
	output wire        mem_reg_sel,
	output wire [16:0] mem_addr,
	output wire [1:0]  mem_be,
	output wire [15:0] mem_wdata,
	input  wire        mem_ack,
	input  wire [15:0] mem_rdata
);

	localparam SYNC_W = 38;
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_REQ  = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	// Pins are sampled twice before use; data and address are only read while
	// the strobes hold them stable, so per-bit skew through the pair is harmless
	reg  [SYNC_W-1:0]      pin_s1_r;
	reg  [SYNC_W-1:0]      pin_s2_r;
	reg  [`HBG_STRAP_W-1:0] strap_s1_r;
	reg  [`HBG_STRAP_W-1:0] strap_s2_r;
	reg                    bclk_d_r;
	reg                    released_r;
	reg  [`HBG_STRAP_W-1:0] strap_r;
	reg  [2:0]             state_r;
	reg  [2:0]             state_nxt;
	reg                    wait_n_r;
	reg                    data_oe_r;
	reg  [15:0]            data_out_r;
	reg                    mem_req_r;
	reg                    mem_we_r;
	reg                    mem_reg_sel_r;
	reg  [16:0]            mem_addr_r;
	reg  [1:0]             mem_be_r;
	reg  [15:0]            mem_wdata_r;
	reg                    panel_r;

	wire [SYNC_W-1:0]      pin_raw;
	wire                   bclk_s;
	wire                   sel_n_s;
	wire                   rd_n_s;
	wire                   wr_n_s;
	wire                   bhe_n_s;
	wire                   a0_s;
	wire [16:1]            addr_hi_s;
	wire [15:0]            data_s;
	wire [16:0]            byte_addr;
	wire                   bclk_rise;
	wire                   mode_ok;
	wire                   order_big;
	wire                   hit_buf;
	wire                   hit_reg;
	wire                   start;
	wire                   cycle_gone;
	wire [1:0]             lane_be;
	wire [15:0]            rdata_lane;

	assign pin_raw = {host_transfer_clock, host_select_n, host_read_n, write_strobe_n,
		high_byte_enable_n, address_bit_zero, host_address_pins, host_data_pins_in};

	// Direction pin is tied high in this mode and carries nothing
	always @(posedge ref_clk)
	begin
		pin_s1_r   <= pin_raw;
		pin_s2_r   <= pin_s1_r;
		strap_s1_r <= {bus_status_strap, panel_power_polarity_strap, byte_order_strap,
			config_strap_2, config_strap_1, config_strap_0};
		strap_s2_r <= strap_s1_r;
	end

	assign bclk_s    = pin_s2_r[37];
	assign sel_n_s   = pin_s2_r[36];
	assign rd_n_s    = pin_s2_r[35];
	assign wr_n_s    = pin_s2_r[34];
	assign bhe_n_s   = pin_s2_r[33];
	assign a0_s      = pin_s2_r[32];
	assign addr_hi_s = pin_s2_r[31:16];
	assign data_s    = pin_s2_r[15:0];
	assign byte_addr = {addr_hi_s, a0_s};

	// Bus clock is found by its sampled rising edge
	// Tracks the pin through reset too, so release never shows a false edge
	always @(posedge ref_clk)
	begin
		bclk_d_r <= bclk_s;
	end
	assign bclk_rise = bclk_s & ~bclk_d_r; // R01

	// Straps are caught in the first cycle after reset lets go
	always @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			released_r <= 1'b0;
			strap_r    <= `HBG_STRAP_RESET;
		end
		else
		begin
			released_r <= 1'b1;
			if (!released_r)
				strap_r <= strap_s2_r; // R11
		end
	end

	assign mode_ok   = released_r & ({strap_r[`HBG_STRAP_CFG2], strap_r[`HBG_STRAP_CFG1],
		strap_r[`HBG_STRAP_CFG0], strap_r[`HBG_STRAP_BUS]} == `HBG_MODE_GENERIC); // R14
	assign order_big = strap_r[`HBG_STRAP_ORDER]; // R12

	// Addresses between buffer end and register block decode to nothing
	assign hit_buf = (byte_addr <= `HBG_BUF_LAST); // R15
	assign hit_reg = (byte_addr >= `HBG_REG_BASE); // R15

	// Little endian: low lane follows even addresses, high lane its own enable; big endian swaps the two
	assign lane_be = order_big ? {~a0_s, ~bhe_n_s} : {~bhe_n_s, ~a0_s}; // R12
	assign rdata_lane = order_big ? {mem_rdata[7:0], mem_rdata[15:8]} : mem_rdata; // R12

	assign start = mode_ok & bclk_rise & ~sel_n_s & (~rd_n_s | ~wr_n_s);
	assign cycle_gone = sel_n_s | (rd_n_s & wr_n_s);

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (start)
					state_nxt = (hit_buf | hit_reg) ? ST_REQ : ST_DONE;
			end
			ST_REQ:
			begin
				if (mem_ack)
					state_nxt = ST_DONE;
			end
			ST_DONE:
			begin
				if (cycle_gone)
					state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Wait drops only after the strobe has crossed the synchroniser, so the host
	// must sample wait no earlier than about three core cycles into its strobe
	always @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			state_r       <= ST_IDLE;
			wait_n_r      <= 1'b1;
			data_oe_r     <= 1'b0;
			data_out_r    <= `HBG_WORD_RESET;
			mem_req_r     <= 1'b0;
			mem_we_r      <= 1'b0;
			mem_reg_sel_r <= 1'b0;
			mem_addr_r    <= `HBG_ADDR_RESET;
			mem_be_r      <= 2'h0;
			mem_wdata_r   <= `HBG_WORD_RESET;
		end
		else
		begin
			state_r <= state_nxt;
			case (state_r)
				ST_IDLE:
				begin
					if (start)
					begin
						mem_we_r      <= ~wr_n_s;
						mem_reg_sel_r <= hit_reg;
						mem_addr_r    <= {addr_hi_s, 1'b0};
						mem_be_r      <= lane_be;
						mem_wdata_r   <= order_big ? {data_s[7:0], data_s[15:8]} : data_s;
						if (hit_buf | hit_reg)
						begin
							mem_req_r <= 1'b1;
							wait_n_r  <= 1'b0; // R08
						end
						else
						begin
							data_out_r <= `HBG_WORD_RESET;
							data_oe_r  <= wr_n_s;
						end
					end
				end
				ST_REQ:
				begin
					if (mem_ack)
					begin
						mem_req_r  <= 1'b0;
						wait_n_r   <= 1'b1; // R08
						data_out_r <= rdata_lane;
						data_oe_r  <= ~mem_we_r;
					end
				end
				ST_DONE:
				begin
					if (cycle_gone)
						data_oe_r <= 1'b0;
				end
				default:
				begin
					mem_req_r <= 1'b0;
					wait_n_r  <= 1'b1;
					data_oe_r <= 1'b0;
				end
			endcase
		end
	end

	always @(posedge ref_clk)
	begin
		if (!nrst)
			panel_r <= 1'b0;
		else
			panel_r <= strap_r[`HBG_STRAP_POWER] ? panel_power_on : ~panel_power_on; // R13
	end

	assign host_wait_n         = wait_n_r;
	assign host_data_pins_out  = data_out_r;
	assign host_data_pins_oe   = data_oe_r;
	assign panel_power_control = panel_r;
	assign generic_mode        = mode_ok;
	assign big_endian          = order_big;
	assign mem_req             = mem_req_r;
	assign mem_we              = mem_we_r;
	assign mem_reg_sel         = mem_reg_sel_r;
	assign mem_addr            = mem_addr_r;
	assign mem_be              = mem_be_r;
	assign mem_wdata           = mem_wdata_r;

endmodule

// *** tb/hbg_arb_model.sv ***
// Arbiter stand-in: acks a request after a set latency with address-derived data
`timescale 1ns/1ps
module hbg_arb_model
(
	input  wire        ref_clk,
	input  wire        mem_req,
	input  wire [16:0] mem_addr,
	input  wire [3:0]  lat,
	output reg         mem_ack = 0,
	output reg  [15:0] mem_rdata = 0
);
	reg [3:0] cnt_r = 0;
	always @(posedge ref_clk)
	begin
		mem_ack <= 1'b0;
		// Stale data toggles so it never passes for valid
		mem_rdata <= ~mem_rdata;
		if (!mem_req || mem_ack)
			cnt_r <= 4'h0;
		else if (cnt_r == lat)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= {8'hC3 ^ mem_addr[7:0], mem_addr[7:0]};
		end
		else
			cnt_r <= cnt_r + 4'h1;
	end
endmodule

// *** tb/hbg_host_port_properties.sv ***
// Concurrent checks on the host port outputs
`timescale 1ns/1ps
module hbg_host_port_properties
(
	input logic        ref_clk,
	input logic        nrst,
	input logic        host_wait_n,
	input logic [15:0] host_data_pins_out,
	input logic        host_data_pins_oe,
	input logic        bus_status_strap,
	input logic        config_strap_0,
	input logic        config_strap_1,
	input logic        config_strap_2,
	input logic        byte_order_strap,
	input logic        panel_power_polarity_strap,
	input logic        panel_power_on,
	input logic        panel_power_control,
	input logic        generic_mode,
	input logic        big_endian,
	input logic        mem_req,
	input logic        mem_we,
	input logic        mem_reg_sel,
	input logic [16:0] mem_addr,
	input logic        mem_ack,
	input logic [15:0] mem_rdata
);
	logic [15:0] rd_q;
	always_ff @(posedge ref_clk)
		rd_q <= mem_rdata;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_settled; nrst [*3]; endsequence
	sequence s_read_ack; mem_ack && !mem_we; endsequence
	a_wait_while_req:
		assert property (mem_req |-> !host_wait_n) else $error("wait high in request");
	a_ack_release:
		assert property (mem_ack |=> host_wait_n && !mem_req) else $error("no release");
	a_read_data:
		assert property (s_read_ack |=> host_data_pins_oe && host_data_pins_out ==
			(big_endian ? {rd_q[7:0], rd_q[15:8]} : rd_q)) else $error("bad read data");
	a_mode_decode:
		assert property (s_settled |-> generic_mode == (config_strap_2 & config_strap_1 &
			config_strap_0 & bus_status_strap)) else $error("bad mode");
	a_order_strap:
		assert property (s_settled |-> big_endian == byte_order_strap) else $error("bad order");
	a_power_pol:
		assert property (s_settled |-> panel_power_control ==
			!($past(panel_power_on) ^ panel_power_polarity_strap)) else $error("bad power");
	a_reg_decode:
		assert property ($rose(mem_req) |-> mem_reg_sel == (mem_addr >= 17'h1FFE0)
			&& !mem_addr[0]) else $error("bad decode");
endmodule
bind hbg_host_port hbg_host_port_properties chk_u (.ref_clk(ref_clk), .nrst(nrst),
	.host_wait_n(host_wait_n), .host_data_pins_out(host_data_pins_out),
	.host_data_pins_oe(host_data_pins_oe), .bus_status_strap(bus_status_strap),
	.config_strap_0(config_strap_0), .config_strap_1(config_strap_1),
	.config_strap_2(config_strap_2), .byte_order_strap(byte_order_strap),
	.panel_power_polarity_strap(panel_power_polarity_strap), .panel_power_on(panel_power_on),
	.panel_power_control(panel_power_control), .generic_mode(generic_mode),
	.big_endian(big_endian), .mem_req(mem_req), .mem_we(mem_we), .mem_reg_sel(mem_reg_sel),
	.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

// *** tb/tb.sv ***
// Bench for the host port: straps, mapped writes and reads, unmapped gap
`timescale 1ns/1ps
module tb;
	reg         ref_clk = 0, nrst = 0, hclk = 0, sel_n = 1, wr_n = 1, rd_n = 1, a0 = 0;
	reg         pon = 0, waited = 0, rs = 0, we_c = 0;
	reg  [16:1] ap = 0;
	reg  [15:0] din = 0, wd_c = 0;
	reg  [16:0] a_c = 0;
	reg  [5:0]  st = 6'h3F;
	reg  [7:0]  rdv = 0;
	reg  [3:0]  lat = 0;
	reg  [1:0]  be_c = 0;
	wire [15:0] dout, rdata, wd;
	wire [16:0] ma;
	wire [1:0]  be;
	wire        oe, wait_n, ppc, gen, bige, req, we, rsel, ack;
	wire        cpu_wait = ~wait_n;
	integer     num_errors = 0, n_tests = 0, i;
	always #12.5 ref_clk = ~ref_clk;
	always #100 hclk = ~hclk;
	always @(posedge ref_clk)
		if (ack)
			{a_c, be_c, wd_c, rs, we_c} <= {ma, be, wd, rsel, we};
	hbg_host_port dut_u (.ref_clk(ref_clk), .nrst(nrst), .host_transfer_clock(hclk),
		.host_address_pins(ap), .address_bit_zero(a0), .host_data_pins_in(din),
		.host_data_pins_out(dout), .host_data_pins_oe(oe), .host_select_n(sel_n),
		.high_byte_enable_n(~a0), .write_strobe_n(wr_n), .host_read_n(rd_n),
		.host_dir_pin(1'b1), .host_wait_n(wait_n), .bus_status_strap(st[5]),
		.config_strap_0(st[0]),
		.config_strap_1(st[1]), .config_strap_2(st[2]), .byte_order_strap(st[3]),
		.panel_power_polarity_strap(st[4]), .panel_power_on(pon), .panel_power_control(ppc),
		.generic_mode(gen), .big_endian(bige), .mem_req(req), .mem_we(we), .mem_reg_sel(rsel),
		.mem_addr(ma), .mem_be(be), .mem_wdata(wd), .mem_ack(ack), .mem_rdata(rdata));
	hbg_arb_model arb_u (.ref_clk(ref_clk), .mem_req(req), .mem_addr(ma), .lat(lat),
		.mem_ack(ack), .mem_rdata(rdata));
	task chk(input [31:0] s, input [31:0] e);
	begin
		n_tests = n_tests + 1;
		if (s !== e)
		begin
			num_errors = num_errors + 1;
			$display("wrong value at %0t: %h, expected %h", $time, s, e);
		end
	end
	endtask
	task end_of_test;
	begin
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task rst(input [5:0] s);
	begin
		nrst <= 0;
		st <= s;
		repeat (8) @(posedge ref_clk);
		nrst <= 1;
		repeat (4) @(negedge ref_clk);
	end
	endtask
	// Glue: high enable is inverted address bit zero, byte mirrored on both lanes
	task cyc(input [16:0] a, input w, input [7:0] d);
	begin
		@(posedge ref_clk);
		{ap, a0} <= a;
		din <= {d, d};
		sel_n <= 0;
		wr_n <= !w;
		rd_n <= w;
		waited = 0;
		for (i = 0; i < 60 && wait_n !== 0 && oe !== 1; i = i + 1)
			@(negedge ref_clk);
		waited = (cpu_wait === 1);
		for (i = 0; i < 200 && !(wait_n === 1 && (w || oe === 1)); i = i + 1)
			@(negedge ref_clk);
		if (i == 200)
		begin
			num_errors = num_errors + 1;
			end_of_test;
		end
		rdv = a[0] ? dout[15:8] : dout[7:0];
		@(posedge ref_clk);
		{sel_n, wr_n, rd_n} <= 3'h7;
		din <= ~din;
		repeat (12) @(posedge ref_clk);
		chk(oe, 0);
	end
	endtask
	task t_straps;
	begin
		pon <= 1;
		rst(6'h08);
		chk(gen, 0);
		chk(bige, 1);
		chk(ppc, 0);
		cyc(17'h00001, 1, 8'h5A);
		chk(waited, 0);
		rst(6'h37);
		chk(gen, 1);
		chk(bige, 0);
		chk(ppc, 1);
		@(posedge ref_clk);
		pon <= 0;
		repeat (3) @(negedge ref_clk);
		chk(ppc, 0);
		$display("strap test done");
	end
	endtask
	task t_write;
	begin
		lat <= 6;
		cyc(17'h00A01, 1, 8'h3C);
		chk(waited, 1);
		chk({a_c[16:1], be_c, wd_c[15:8], rs}, {16'h0500, 2'b10, 8'h3C, 1'b0});
		chk(we_c, 1);
		cyc(17'h1FFE0, 1, 8'h81);
		chk({a_c[16:1], be_c, wd_c[7:0], rs}, {16'hFFF0, 2'b01, 8'h81, 1'b1});
		chk(a_c[16], 1);
		$display("write test done");
	end
	endtask
	task t_read;
	begin
		lat <= 0;
		cyc(17'h00B07, 0, 0);
		chk(rdv, 8'hC5);
		chk(we_c, 0);
		cyc(17'h1FFE2, 0, 0);
		chk(rdv, 8'hE2);
		cyc(17'h14000, 0, 0);
		chk({waited, rdv}, 0);
		$display("read test done");
	end
	endtask
	// Big endian: odd bytes sit on the low lane of the memory word
	task t_big;
	begin
		rst(6'h2F);
		chk(gen, 1);
		chk(bige, 1);
		chk(ppc, 1);
		cyc(17'h00A01, 1, 8'h3C);
		chk({a_c[16:1], be_c, wd_c[7:0], rs}, {16'h0500, 2'b01, 8'h3C, 1'b0});
		cyc(17'h00B07, 0, 0);
		chk(rdv, 8'h06);
		$display("big endian test done");
	end
	endtask
	initial
	begin
		t_straps;
		t_write;
		t_read;
		t_big;
		end_of_test;
	end
endmodule
